//--- rtl/ppm_fifo.sv
// tagged byte fifo with registered head word
`timescale 1ns/1ps
module ppm_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  // clock and control
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic         flush_i,
  input  wire logic         wrap_i,
  // fill side
  input  wire logic         wr_valid_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic              wr_ready_o,
  // drain side
  output logic              rd_valid_o,
  output logic [W-1:0]      rd_data_o,
  input  wire logic         rd_ready_i,
  // level
  output logic              full_o,
  output logic              empty_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            head;
  } ppm_fst_t;

  ppm_fst_t st_ff;
  ppm_fst_t nxt;
  logic     push;
  logic     pop;

  assign full_o     = st_ff.cnt == (AW+1)'(DEPTH);
  assign empty_o    = st_ff.cnt == '0;
  assign wr_ready_o = wrap_i || !full_o;
  assign rd_valid_o = wrap_i || !empty_o;
  assign rd_data_o  = st_ff.head;

  always_comb
  begin
    nxt  = st_ff;
    push = wr_valid_i && wr_ready_o;
    pop  = rd_ready_i && rd_valid_o;
    if (push)
    begin
      nxt.mem[st_ff.wp] = wr_data_i;
      nxt.wp = st_ff.wp + 1'b1;
    end
    if (pop)
      nxt.rp = st_ff.rp + 1'b1;
    if (push && !pop && !full_o)
      nxt.cnt = st_ff.cnt + 1'b1;
    else if (pop && !push && !empty_o)
      nxt.cnt = st_ff.cnt - 1'b1;
    if (flush_i)
    begin
      nxt.wp  = '0;
      nxt.rp  = '0;
      nxt.cnt = '0;
    end
    nxt.head = nxt.mem[nxt.rp];
    if (!resetn_i)
      nxt = '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i || !resetn_i)
      st_ff <= nxt;
  end

endmodule

//--- rtl/ppm_pkg.sv
// constants and carrier types of the parallel port controller
package ppm_pkg;

  // ==========================================================
  // mode field codes
  localparam logic [2:0] MODE_STD  = 3'h0;
  localparam logic [2:0] MODE_BIDI = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_EPP  = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG  = 3'h7;

  // ==========================================================
  // offsets under each chip select
  localparam logic [2:0] OFS_DATA  = 3'h0;
  localparam logic [2:0] OFS_STAT  = 3'h1;
  localparam logic [2:0] OFS_CTRL  = 3'h2;
  localparam logic [2:0] OFS_EPPA  = 3'h3;
  localparam logic [2:0] OFS_EPPD  = 3'h4;
  localparam logic [2:0] OFS_XFIFO = 3'h0;
  localparam logic [2:0] OFS_XCFGB = 3'h1;
  localparam logic [2:0] OFS_XECR  = 3'h2;

  // ==========================================================
  // field positions and fixed values
  localparam int         ECR_MODE_LSB = 5;
  localparam int         ECR_FULL     = 1;
  localparam int         ECR_EMPTY    = 0;
  localparam int         DCR_DIR      = 5;
  localparam int         DCR_SLIN     = 3;
  localparam int         DCR_INIT     = 2;
  localparam int         DCR_AFD      = 1;
  localparam int         DCR_STB      = 0;
  localparam logic [1:0] DCR_RSVD     = 2'h3;
  localparam logic [7:0] CFGA_VAL     = 8'h1f;
  localparam logic [7:0] CFGB_VAL     = 8'h0b;
  localparam logic [7:0] RD_NONE      = 8'h00;
  localparam int         RLE_FLAG     = 7;

  // ==========================================================
  // fifo shape and timing
  localparam int         FIFO_DEPTH = 16;
  localparam int         FIFO_W     = 9;
  localparam int         TAG_BIT    = 8;
  localparam int         CLK_MHZ    = 50;
  localparam int         STB_NS     = 500;
  localparam logic [5:0] STB_CYC    = 6'((STB_NS * CLK_MHZ + 999) / 1000);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       pcs;
    logic       ecs;
    logic       dack;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ppm_req_t;

  typedef struct packed {
    logic [7:0] pd;
    logic       ack_n;
    logic       busy;
    logic       perror;
    logic       select;
    logic       fault_n;
  } ppm_pins_t;

  typedef struct packed {
    logic strobe_n;
    logic autofd_n;
    logic init_n;
    logic selectin_n;
  } ppm_ctl_t;

  typedef enum logic [3:0] {
    SQ_IDLE,
    SQ_CP_STB,
    SQ_CP_ACK,
    SQ_EF_CLK,
    SQ_EF_REL,
    SQ_ER_REL,
    SQ_EPP_STB,
    SQ_EPP_END
  } ppm_sq_t;

endpackage

//--- rtl/ppm_port.sv
// parallel port controller: registers, fifo path and protocol sequencer
`timescale 1ns/1ps
module ppm_port (
  // clock, reset, enable
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  // host bus
  input  wire ppm_pkg::ppm_req_t host_i,
  output logic [7:0]            host_rdata_o,
  output logic                  host_wait_o,
  output logic                  port_dma_request_o,
  // parallel interface
  input  wire ppm_pkg::ppm_pins_t pins_i,
  output logic [7:0]            pd_o,
  output logic                  pd_oe_o,
  output ppm_pkg::ppm_ctl_t     ctl_o
);
  import ppm_pkg::*;

  typedef struct packed {
    ppm_pins_t  s1;
    ppm_pins_t  s2;
    logic [2:0] mode;
    logic [2:0] prev;
    logic       dir;
    logic [4:0] line_control;
    logic       print;
    logic       ack_d;
    logic [7:0] pd;
    logic       pd_oe;
    logic [7:0] rdata;
    logic       wait_f;
    logic       dreq;
    ppm_ctl_t   ctl;
    ppm_sq_t    sq;
    logic [5:0] tmr;
    logic       epp_rd;
    logic [6:0] rle;
  } ppm_st_t;

  ppm_st_t             st_ff;
  ppm_st_t             nxt;
  logic                h_push;
  logic                s_push;
  logic                h_pop;
  logic                s_pop;
  logic                rle_pop;
  logic [FIFO_W-1:0]   f_wdata;
  logic [FIFO_W-1:0]   f_head;
  logic                f_valid;
  logic                f_ready;
  logic                f_full;
  logic                f_empty;
  logic                flush;
  logic                fwd;
  logic                rev;
  logic                busy;
  logic                ack_n;
  logic                ack_rise;
  logic                acc;

  // ==========================================================
  // helpers
  function automatic logic fwd_mode(input logic [2:0] m, input logic d);
    fwd_mode = m == MODE_FIFO || m == MODE_TEST || (m == MODE_ECP && !d);
  endfunction

  function automatic logic rev_mode(input logic [2:0] m, input logic d);
    rev_mode = m == MODE_TEST || (m == MODE_ECP && d);
  endfunction

  // ==========================================================
  // outputs
  assign host_rdata_o       = st_ff.rdata;
  assign host_wait_o        = st_ff.wait_f;
  assign port_dma_request_o = st_ff.dreq;
  assign pd_o               = st_ff.pd;
  assign pd_oe_o            = st_ff.pd_oe;
  assign ctl_o              = st_ff.ctl;

  assign fwd      = fwd_mode(st_ff.mode, st_ff.dir);
  assign rev      = rev_mode(st_ff.mode, st_ff.dir);
  assign busy     = st_ff.s2.busy;
  assign ack_n    = st_ff.s2.ack_n;
  assign ack_rise = ack_n && !st_ff.ack_d;
  assign acc      = !st_ff.wait_f;

  // standard mode holds fifo in reset; leaving fifo/ecp discards it
  assign flush = st_ff.mode == MODE_STD ||
    (st_ff.prev != st_ff.mode && (st_ff.prev == MODE_FIFO || st_ff.prev == MODE_ECP));

  // ==========================================================
  // fifo
  ppm_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (sys_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .flush_i    (flush),
    .wrap_i     (st_ff.mode == MODE_TEST),
    .wr_valid_i (h_push || s_push),
    .wr_data_i  (f_wdata),
    .wr_ready_o (f_ready),
    .rd_valid_o (f_valid),
    .rd_data_o  (f_head),
    .rd_ready_i (h_pop || s_pop || rle_pop),
    .full_o     (f_full),
    .empty_o    (f_empty)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    nxt     = st_ff;
    h_push  = 1'b0;
    s_push  = 1'b0;
    h_pop   = 1'b0;
    s_pop   = 1'b0;
    rle_pop = 1'b0;
    f_wdata = '0;
    nxt.s1    = pins_i;
    nxt.s2    = st_ff.s1;
    nxt.ack_d = ack_n;
    nxt.prev  = st_ff.mode;

    // sequencer
    unique case (st_ff.sq)
      SQ_IDLE:
      begin
        nxt.ctl.init_n     = st_ff.line_control[DCR_INIT];
        nxt.ctl.strobe_n   = !st_ff.line_control[DCR_STB];
        nxt.ctl.autofd_n   = !st_ff.line_control[DCR_AFD];
        nxt.ctl.selectin_n = !st_ff.line_control[DCR_SLIN];
        nxt.pd_oe = st_ff.mode == MODE_STD || st_ff.mode == MODE_FIFO || !st_ff.dir;
        if (st_ff.mode == MODE_FIFO || st_ff.mode == MODE_EPP)
        begin
          nxt.ctl.strobe_n   = 1'b1;
          nxt.ctl.autofd_n   = 1'b1;
          nxt.ctl.selectin_n = 1'b1;
        end
        if (st_ff.mode == MODE_ECP)
        begin
          nxt.ctl.strobe_n = 1'b1;
          nxt.ctl.autofd_n = !st_ff.dir;
        end
        // test and config modes start nothing on the port
        if (st_ff.mode == MODE_FIFO && f_valid && !busy)
        begin
          s_pop            = 1'b1;
          nxt.pd           = f_head[7:0];
          nxt.ctl.strobe_n = 1'b0;
          nxt.tmr          = STB_CYC - 1'b1;
          nxt.sq           = SQ_CP_STB;
        end
        else if (st_ff.mode == MODE_ECP && !st_ff.dir && f_valid && !busy)
        begin
          s_pop            = 1'b1;
          nxt.pd           = f_head[7:0];
          nxt.ctl.autofd_n = !f_head[TAG_BIT];
          nxt.ctl.strobe_n = 1'b0;
          nxt.sq           = SQ_EF_CLK;
        end
        else if (st_ff.mode == MODE_ECP && st_ff.dir && !ack_n && f_ready)
        begin
          s_push           = 1'b1;
          f_wdata          = {!busy, st_ff.s2.pd};
          nxt.ctl.autofd_n = 1'b1;
          nxt.sq           = SQ_ER_REL;
        end
      end
      SQ_CP_STB:
      begin
        if (st_ff.tmr == '0)
        begin
          nxt.ctl.strobe_n = 1'b1;
          nxt.sq           = SQ_CP_ACK;
        end
        else
          nxt.tmr = st_ff.tmr - 1'b1;
      end
      SQ_CP_ACK:
      begin
        if (ack_rise)
          nxt.sq = SQ_IDLE;
      end
      SQ_EF_CLK:
      begin
        if (busy)
        begin
          nxt.ctl.strobe_n = 1'b1;
          nxt.sq           = SQ_EF_REL;
        end
      end
      SQ_EF_REL:
      begin
        if (!busy)
          nxt.sq = SQ_IDLE;
      end
      SQ_ER_REL:
      begin
        if (ack_n)
        begin
          nxt.ctl.autofd_n = 1'b0;
          nxt.sq           = SQ_IDLE;
        end
      end
      SQ_EPP_STB:
      begin
        if (busy)
        begin
          if (st_ff.epp_rd)
            nxt.rdata = st_ff.s2.pd;
          nxt.ctl.selectin_n = 1'b1;
          nxt.ctl.autofd_n   = 1'b1;
          nxt.sq             = SQ_EPP_END;
        end
      end
      SQ_EPP_END:
      begin
        if (!busy)
        begin
          nxt.ctl.strobe_n = 1'b1;
          nxt.wait_f       = 1'b0;
          nxt.pd_oe        = !st_ff.dir;
          nxt.sq           = SQ_IDLE;
        end
      end
    endcase

    // host writes
    if (acc && host_i.wr)
    begin
      if (host_i.dack)
      begin
        if (fwd)
        begin
          h_push  = 1'b1;
          f_wdata = {1'b0, host_i.wdata};
        end
      end
      else if (host_i.pcs)
      begin
        if (host_i.addr == OFS_DATA)
        begin
          if (st_ff.mode == MODE_ECP && !st_ff.dir)
          begin
            h_push  = 1'b1;
            f_wdata = {1'b1, host_i.wdata};
          end
          else
            nxt.pd = host_i.wdata;
        end
        else if (host_i.addr == OFS_CTRL)
        begin
          nxt.dir = host_i.wdata[DCR_DIR];
          nxt.line_control = host_i.wdata[4:0];
        end
        else if (host_i.addr >= OFS_EPPA && st_ff.mode == MODE_EPP && st_ff.sq == SQ_IDLE)
        begin
          nxt.pd       = host_i.wdata;
          nxt.pd_oe    = 1'b1;
          nxt.epp_rd   = 1'b0;
          nxt.wait_f   = 1'b1;
          nxt.ctl.strobe_n = 1'b0;
          nxt.ctl.selectin_n = host_i.addr != OFS_EPPA;
          nxt.ctl.autofd_n = host_i.addr < OFS_EPPD;
          nxt.sq       = SQ_EPP_STB;
        end
      end
      else if (host_i.ecs)
      begin
        if (host_i.addr == OFS_XFIFO && fwd)
        begin
          h_push  = 1'b1;
          f_wdata = {1'b0, host_i.wdata};
        end
        else if (host_i.addr == OFS_XECR)
          nxt.mode = host_i.wdata[7:ECR_MODE_LSB];
      end
    end

    // host reads
    if (acc && host_i.rd)
    begin
      nxt.rdata = RD_NONE;
      if (host_i.dack || (host_i.ecs && host_i.addr == OFS_XFIFO && st_ff.mode != MODE_CFG))
      begin
        nxt.rdata = f_head[7:0];
        if (rev)
        begin
          if (st_ff.rle != '0)
            nxt.rle = st_ff.rle - 1'b1;
          else
            h_pop = 1'b1;
        end
      end
      else if (host_i.pcs)
      begin
        if (host_i.addr == OFS_DATA)
          nxt.rdata = st_ff.s2.pd;
        else if (host_i.addr == OFS_STAT)
        begin
          nxt.rdata = {!busy, ack_n, st_ff.s2.perror, st_ff.s2.select,
                       st_ff.s2.fault_n, st_ff.print, 2'h0};
          nxt.print = 1'b1;
        end
        else if (host_i.addr == OFS_CTRL)
          nxt.rdata = {DCR_RSVD, st_ff.dir, st_ff.line_control};
        else if (st_ff.mode == MODE_EPP && st_ff.sq == SQ_IDLE)
        begin
          nxt.pd_oe    = 1'b0;
          nxt.epp_rd   = 1'b1;
          nxt.wait_f   = 1'b1;
          nxt.ctl.strobe_n = 1'b1;
          nxt.ctl.selectin_n = host_i.addr != OFS_EPPA;
          nxt.ctl.autofd_n = host_i.addr < OFS_EPPD;
          nxt.sq       = SQ_EPP_STB;
        end
      end
      else if (host_i.ecs)
      begin
        if (host_i.addr == OFS_XFIFO)
          nxt.rdata = CFGA_VAL;
        else if (host_i.addr == OFS_XCFGB && st_ff.mode == MODE_CFG)
          nxt.rdata = CFGB_VAL;
        else if (host_i.addr == OFS_XECR)
        begin
          nxt.rdata = {st_ff.mode, 5'h00};
          nxt.rdata[ECR_FULL]  = f_full;
          nxt.rdata[ECR_EMPTY] = f_empty;
        end
      end
    end

    // count byte leaves fifo into the decompression counter
    if (st_ff.mode == MODE_ECP && st_ff.dir && !h_pop && !f_empty && f_head[TAG_BIT])
    begin
      rle_pop = 1'b1;
      if (!f_head[RLE_FLAG])
        nxt.rle = f_head[6:0];
    end

    // acknowledge end wins over a status read
    if (ack_rise)
      nxt.print = 1'b0;

    // dma only for real data bytes
    if (st_ff.mode == MODE_TEST)
      nxt.dreq = st_ff.dir ? !f_empty : !f_full;
    else if (rev)
      nxt.dreq = !f_empty && !f_head[TAG_BIT];
    else
      nxt.dreq = fwd && f_ready;

    // a mode change aborts any cycle in flight
    if (st_ff.mode != st_ff.prev)
    begin
      nxt.sq     = SQ_IDLE;
      nxt.wait_f = 1'b0;
      nxt.rle    = '0;
    end

    if (!resetn_i)
    begin
      nxt       = '0;
      nxt.mode  = MODE_STD;
      nxt.prev  = MODE_STD;
      nxt.sq    = SQ_IDLE;
      nxt.pd_oe = 1'b1;
      nxt.print = 1'b1;
      // sync chain starts at the idle pin level, so no false acknowledge edge
      nxt.s1.ack_n = 1'b1;
      nxt.s2.ack_n = 1'b1;
      nxt.ack_d    = 1'b1;
      nxt.ctl   = '{strobe_n: 1'b1, autofd_n: 1'b1, init_n: 1'b0, selectin_n: 1'b1};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i || !resetn_i)
      st_ff <= nxt;
  end

  // ==========================================================
  // checks
  sequence s_hostclk_held;
    ce_i && st_ff.sq == SQ_EF_CLK && busy && st_ff.mode == st_ff.prev;
  endsequence

  sequence s_epp_launch;
    ce_i && acc && host_i.wr && host_i.pcs && !host_i.dack && host_i.addr >= OFS_EPPA &&
      st_ff.mode == MODE_EPP && st_ff.sq == SQ_IDLE && st_ff.mode == st_ff.prev;
  endsequence

  a_reset_mode: assert property (@(posedge sys_clk_i)
    !resetn_i |=> st_ff.mode == MODE_STD && st_ff.sq == SQ_IDLE && !port_dma_request_o)
    else $error("reset left mode or sequencer");

  a_std_drive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && st_ff.mode == MODE_STD && st_ff.prev == MODE_STD |=> pd_oe_o && f_empty)
    else $error("standard mode not driving or fifo kept");

  a_bidir_float: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && st_ff.mode == MODE_BIDI && st_ff.dir && st_ff.sq == SQ_IDLE |=> !pd_oe_o)
    else $error("reverse direction still drives");

  a_ecp_release: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_hostclk_held |=> ctl_o.strobe_n && st_ff.sq == SQ_EF_REL)
    else $error("host clock not released");

  a_epp_strobe: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_epp_launch |=> host_wait_o && !ctl_o.strobe_n && (ctl_o.selectin_n != ctl_o.autofd_n))
    else $error("epp write strobes wrong");

  a_cfga_read: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && acc && host_i.rd && host_i.ecs && !host_i.dack && host_i.addr == OFS_XFIFO &&
      st_ff.mode == MODE_CFG |=> host_rdata_o == CFGA_VAL)
    else $error("config word a not returned");

  a_leave_flush: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && st_ff.prev != st_ff.mode && (st_ff.prev == MODE_ECP || st_ff.prev == MODE_FIFO)
      |=> f_empty && st_ff.sq == SQ_IDLE)
    else $error("fifo kept after leaving mode");

  a_rle_repeat: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && acc && host_i.rd && (host_i.dack || (host_i.ecs && host_i.addr == OFS_XFIFO)) &&
      rev && st_ff.rle != '0 && st_ff.mode == st_ff.prev
      |=> st_ff.rle == $past(st_ff.rle) - 1'b1)
    else $error("repeat count not consumed");

  a_cmd_no_dma: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && rev && st_ff.mode == MODE_ECP && !f_empty && f_head[TAG_BIT] |=> !port_dma_request_o)
    else $error("dma raised for count byte");

  a_cp_width: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i && st_ff.sq == SQ_CP_STB && st_ff.tmr != '0 && st_ff.mode == st_ff.prev |=> !ctl_o.strobe_n)
    else $error("strobe ended early");

endmodule

//--- testbench/ieee1284_parallel_port_modes_tb_top.sv
// self-checking bench of the parallel port controller
`timescale 1ns/1ps
module ieee1284_parallel_port_modes_tb_top;
  import ppm_pkg::*;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [1:0] pmode = 2'h0;
  ppm_req_t   hq = '0;
  ppm_pins_t  pins;
  ppm_pins_t  pin_d;
  ppm_ctl_t   ctl;
  logic [7:0] rdata;
  logic [7:0] pd_o;
  logic       hwait;
  logic       dreq;
  logic       pd_oe;
  logic [8:0] exp_q[$];
  logic [7:0] b;
  int         failures = 0;
  int         cmp_count = 0;

  always #10 sys_clk = ~sys_clk;
  always_comb
  begin
    pin_d = pins;
    pin_d.pd = pd_oe ? pd_o : pins.pd;
  end

  ppm_port DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .ce_i(1'b1), .host_i(hq),
    .host_rdata_o(rdata), .host_wait_o(hwait), .port_dma_request_o(dreq),
    .pins_i(pin_d), .pd_o(pd_o), .pd_oe_o(pd_oe), .ctl_o(ctl));
  ppm_peer peer (.clk_i(sys_clk), .mode_i(pmode), .pd_i(pin_d.pd), .ctl_i(ctl), .pins_o(pins));

  // ==========================================================
  // host access and comparison
  task automatic chk(input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] cs, input logic [2:0] a, input logic [7:0] d);
    hq = '{pcs:cs[1], ecs:cs[0], dack:1'b0, rd:!w, wr:w, addr:a, wdata:d};
    @(posedge sys_clk);
    #1;
    hq.rd = 1'b0;
    hq.wr = 1'b0;
    for (int i = 0; i < 300 && hwait !== 1'b0; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, cs, a, 8'h00);
    chk({1'b0, e}, {1'b0, rdata});
  endtask
  task automatic mode_control(input logic [7:0] d);
    acc(1'b1, 2'h1, OFS_XECR, d);
  endtask
  task automatic put(input logic [1:0] cs, input logic [2:0] a, input logic t);
    b = 8'($urandom());
    exp_q.push_back({t, b});
    acc(1'b1, cs, a, b);
  endtask
  task automatic drain;
    for (int i = 0; i < 2000 && peer.rx_q.size() < exp_q.size(); i++)
      @(posedge sys_clk);
    // let the link finish before a mode change
    repeat (60) @(posedge sys_clk);
    #1;
    while (exp_q.size() > 0)
      chk(exp_q.pop_front(), peer.rx_q.size() > 0 ? peer.rx_q.pop_front() : 9'h1ff);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #1000000;
    failures++;
    stop_test();
  end

  // ==========================================================
  // scenarios
  initial
  begin
    void'($urandom(32'h7fcb));
    repeat (10) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    rd(2'h1, OFS_XECR, 8'h01);
    rd(2'h2, OFS_CTRL, 8'hc0);
    rd(2'h2, OFS_STAT, 8'hdc);
    rd(2'h1, 3'h3, RD_NONE);
    chk(9'h00b, {5'h0, pd_oe, ctl.init_n, ctl.strobe_n, ctl.selectin_n});
    acc(1'b1, 2'h2, OFS_CTRL, 8'h20);
    chk(9'h001, {8'h0, pd_oe});
    mode_control(8'h20);
    chk(9'h000, {8'h0, pd_oe});
    rd(2'h2, OFS_CTRL, 8'he0);
    rd(2'h2, OFS_DATA, pins.pd);
    acc(1'b1, 2'h2, OFS_CTRL, 8'h00);
    mode_control(8'he0);
    rd(2'h1, OFS_XECR, 8'he1);
    rd(2'h1, OFS_XFIFO, CFGA_VAL);
    rd(2'h1, OFS_XCFGB, CFGB_VAL);
    mode_control(8'h20);
    rd(2'h1, OFS_XCFGB, RD_NONE);
    mode_control(8'hc0);
    repeat (16) put(2'h1, OFS_XFIFO, 1'b0);
    rd(2'h1, OFS_XECR, 8'hc2);
    chk(9'h000, {8'h0, dreq});
    for (int i = 0; i < 16; i++)
      rd(2'h1, OFS_XFIFO, exp_q[i][7:0]);
    exp_q.delete();
    rd(2'h1, OFS_XECR, 8'hc1);
    mode_control(8'h20);
    mode_control(8'h40);
    repeat (3) put(2'h1, OFS_XFIFO, 1'b0);
    chk(9'h001, {8'h0, dreq});
    drain();
    mode_control(8'h20);
    mode_control(8'h60);
    put(2'h2, OFS_DATA, 1'b1);
    put(2'h1, OFS_XFIFO, 1'b0);
    drain();
    mode_control(8'h20);
    pmode = 2'h1;
    mode_control(8'h80);
    put(2'h2, OFS_EPPA, 1'b0);
    drain();
    acc(1'b1, 2'h2, OFS_CTRL, 8'h20);
    b = 8'($urandom());
    peer.tx_q.push_back({1'b0, b});
    rd(2'h2, OFS_EPPD, b);
    mode_control(8'h20);
    peer.tx_q.push_back({1'b1, 8'h03});
    b = 8'($urandom());
    peer.tx_q.push_back({1'b0, b});
    pmode = 2'h2;
    mode_control(8'h60);
    for (int i = 0; i < 300 && dreq !== 1'b1; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    repeat (8'h03 + 1) rd(2'h1, OFS_XFIFO, b);
    chk(9'h000, {8'h0, dreq});
    rd(2'h1, OFS_XECR, 8'h61);
    stop_test();
  end
endmodule

//--- testbench/ppm_peer.sv
// printer-side model of the parallel link
`timescale 1ns/1ps
module ppm_peer
  import ppm_pkg::*;
(
  // link
  input  wire logic               clk_i,
  input  wire logic [1:0]         mode_i,
  input  wire logic [7:0]         pd_i,
  input  wire ppm_pkg::ppm_ctl_t  ctl_i,
  output ppm_pkg::ppm_pins_t      pins_o
);
  logic [8:0] rx_q[$];
  logic [8:0] tx_q[$];
  logic [8:0] w;

  // ==========================================================
  // handshakes: mode 0 strobe driven, mode 1 auto strobes, mode 2 reverse
  initial
  begin
    pins_o = '{pd:8'h5a, ack_n:1'b1, busy:1'b0, perror:1'b0, select:1'b1, fault_n:1'b1};
    forever
    begin
      @(posedge clk_i);
      #1;
      if (mode_i == 2'h1 && !(ctl_i.selectin_n && ctl_i.autofd_n))
      begin
        if (!ctl_i.strobe_n)
          rx_q.push_back({1'b0, pd_i});
        else
        begin
          w = tx_q.pop_front();
          pins_o.pd = w[7:0];
        end
        pins_o.busy = 1'b1;
        wait (ctl_i.selectin_n && ctl_i.autofd_n);
        @(posedge clk_i);
        #1;
        pins_o.busy = 1'b0;
        pins_o.pd = ~pins_o.pd;
      end
      else if (mode_i == 2'h0 && !ctl_i.strobe_n)
      begin
        rx_q.push_back({!ctl_i.autofd_n, pd_i});
        pins_o.busy = 1'b1;
        wait (ctl_i.strobe_n);
        @(posedge clk_i);
        #1;
        pins_o.ack_n = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        pins_o.ack_n = 1'b1;
        pins_o.busy = 1'b0;
      end
      else if (mode_i == 2'h2 && !ctl_i.autofd_n && tx_q.size() > 0)
      begin
        // busy low marks a command byte
        w = tx_q.pop_front();
        pins_o.busy = !w[8];
        pins_o.pd = w[7:0];
        @(posedge clk_i);
        #1;
        pins_o.ack_n = 1'b0;
        wait (ctl_i.autofd_n);
        @(posedge clk_i);
        #1;
        pins_o.ack_n = 1'b1;
        wait (!ctl_i.autofd_n);
      end
    end
  end
endmodule
